// *** el1_store_model.sv ***
/*
  Model of the lower-level label register store beside the bank.
  Assumes the bank pulses the write strobe for one cycle per write.
*/
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Store
// ------------------------------------------------------------------
module el1_store_model (
  input  wire logic        clk_in,
  input  wire logic        write_in,
  input  wire logic [63:0] wdata_in,
  output var  logic [62:0] value_out
);
  // Bit 63 stays in the bank, so only the low bits are kept here.
  initial value_out = 63'h0;
  always @(posedge clk_in) begin
    if (write_in) begin
      value_out <= wdata_in[62:0];
    end
  end
endmodule
`default_nettype wire

// *** label_pkg.sv ***
/*
  Package for the exception-level request label register bank.
  Holds field positions, decode codes, reset values and carrier types.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
package label_pkg;

  // ------------------------------------------------------------------
  // Field positions of the label registers
  // ------------------------------------------------------------------
  localparam int ENABLE_BIT      = 63;
  localparam int LOWER_TRAP_BIT  = 62;
  localparam int EL0_TRAP_BIT    = 49;
  localparam int EL1_TRAP_BIT    = 48;
  localparam int ID_TRAP_BIT     = 31;
  localparam int EL1_VMAP_BIT    = 1;
  localparam int EL0_VMAP_BIT    = 0;

  // ------------------------------------------------------------------
  // System instruction decode codes
  // ------------------------------------------------------------------
  localparam logic [1:0] OP0_SYS      = 2'h3;
  localparam logic [3:0] CRN_LABEL    = 4'ha;
  localparam logic [3:0] CRM_LABEL    = 4'h5;
  localparam logic [3:0] CRM_CTRL     = 4'h4;
  localparam logic [2:0] OP2_LABEL    = 3'h0;
  localparam logic [2:0] OP2_ID       = 3'h4;
  localparam logic [2:0] OP1_EL1      = 3'h0;
  localparam logic [2:0] OP1_EL2      = 3'h4;
  localparam logic [2:0] OP1_EL3      = 3'h6;
  localparam logic [5:0] TRAP_CLASS   = 6'h18;
  localparam logic [11:0] MEM_EL1_OFS = 12'h900;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic RST_ENABLE     = 1'h0;
  localparam logic RST_LOWER_TRAP = 1'h1;
  localparam logic RST_EL2_TRAPS  = 1'h1;
  localparam logic [15:0] DEFAULT_PARTITION = 16'h0000;
  localparam logic [7:0]  DEFAULT_GROUP     = 8'h00;

  typedef enum logic [1:0] {EL0, EL1, EL2, EL3} level_type;

  // Outcome of one system register access.
  typedef enum logic [2:0] {
    ACC_DONE, ACC_UNDEF, ACC_TRAP_EL2, ACC_TRAP_EL3, ACC_MEM
  } outcome_type;

  typedef struct packed {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_code_type;

  typedef struct packed {
    logic [15:0] partition_identifier;
    logic [7:0]  monitoring_group;
  } label_type;

endpackage

// *** partition_label_regs.sv ***
/*
  Register bank for the EL2 and EL3 request label registers and the
  hypervisor label control register, with the access checks of the
  system instruction decoder and the label driven to the memory side.
  Assumes the pipeline presents one access per cycle with its level,
  encoding and the hypervisor configuration bits, and takes the outcome
  one cycle later. Lower-level label registers live elsewhere and are
  presented here as inputs; their bit 63 is this bank's shared enable.
*/
// Overview of operation
// - Enable clear forces default partition and group for every level.
// - With EL3, EL2 enable reads EL3 enable live; else writable.
// - The enable bit clears on reset.
// - Bit 63 is one storage bit shared by EL1, EL2, EL3 registers.
// - EL0 label trap sends EL1 accesses to EL0 register to EL2.
// - EL1 label trap sends EL1 accesses to EL1 register to EL2.
// - Without EL3 the EL2 trap bits reset to one.
// - Registers hold data/instr groups and data/instr partition ids.
// - EL2 register writes from below EL2 undefined or trapped class 0x18.
// - Lower-level trap sends all defined sub-EL3 accesses to EL3.
// - Cold reset sets the lower-level trap bit.
// - At EL2 with host mode, EL1 register name reaches EL2 register.
// - EL1 with nested controls 111 redirects EL1 register to 0x900.
// - EL1 register checks: EL3 trap, EL2 trap, redirect, then register.
// - EL3 register accessible only at EL3; undefined elsewhere.
// - The EL3 enable bit is always writable.
// - EL2 registers have no effect when EL2 is not enabled.
// - Labels come straight from registers, never from cached copies.
// - Hypervisor control register exists only with virtualization.
// - ID trap sends EL1 accesses to the ID register to EL2.
// - Decode op0 11, CRn 1010, CRm 0101, op2 000; op1 selects.
// - Defined reset values apply only when resetting into 64-bit; enable and lower trap reset regardless.
// - Virtual map enable translates partition ids through map entries.
`timescale 1ns/1ps
`default_nettype none

module partition_label_regs #(
  parameter bit HAVE_EL3 = 1'b1,
  parameter bit HAVE_VIRT = 1'b1
) (
  input  wire logic                        clk_in,
  input  wire logic                        reset_in,
  input  wire logic                        cold_reset_in,
  input  wire logic                        reset_64bit_in,
  input  wire logic                        acc_valid_in,
  input  wire logic                        acc_write_in,
  input  wire label_pkg::sysreg_code_type  acc_code_in,
  input  wire label_pkg::level_type        acc_level_in,
  input  wire logic [63:0]                 acc_wdata_in,
  input  wire logic                        el2_enabled_in,
  input  wire logic                        host_mode_control_in,
  input  wire logic                        nested_virt_control_in,
  input  wire logic                        nested_virt_secondary_in,
  input  wire logic                        nested_virt_memory_in,
  input  wire logic                        el0_reg_access_in,
  input  wire logic [62:0]                 el1_label_register_in,
  input  wire label_pkg::level_type        cur_level_in,
  input  wire logic                        req_is_data_in,
  input  wire logic [15:0]                 mapped_partition_in,
  output logic                             el1_write_out,
  output logic [63:0]                      acc_rdata_out,
  output label_pkg::outcome_type           acc_outcome_out,
  output logic [5:0]                       trap_class_out,
  output logic [11:0]                      mem_offset_out,
  output logic                             label_enable_out,
  output logic [15:0]                      virtual_partition_out,
  output logic                             virtual_map_out,
  output label_pkg::label_type             label_out
);

  // ------------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------------
  logic        enable_r;      // Single shared bit 63.
  logic        lower_trap_r;
  logic        el0_trap_r;
  logic        el1_trap_r;
  logic        id_trap_r;
  logic [1:0]  vmap_r;
  logic [47:0] el2_fields_r;
  logic [47:0] el3_fields_r;

  // ------------------------------------------------------------------
  // Decode and access checks
  // ------------------------------------------------------------------
  logic hit_label;
  logic hit_ctrl;
  logic hit_id;
  logic lower_trap_on;
  logic nested_all;
  logic el2_on;
  label_pkg::outcome_type outcome;
  logic wr_el2;
  logic wr_el3;
  logic wr_ctrl;
  logic [63:0] rdata;

  assign hit_label = acc_code_in.op0 == label_pkg::OP0_SYS
      && acc_code_in.crn == label_pkg::CRN_LABEL
      && acc_code_in.crm == label_pkg::CRM_LABEL
      && acc_code_in.op2 == label_pkg::OP2_LABEL;
  assign hit_ctrl = acc_code_in.op0 == label_pkg::OP0_SYS
      && acc_code_in.crn == label_pkg::CRN_LABEL
      && acc_code_in.crm == label_pkg::CRM_CTRL
      && acc_code_in.op1 == label_pkg::OP1_EL2
      && acc_code_in.op2 == label_pkg::OP2_LABEL;
  assign hit_id = acc_code_in.op0 == label_pkg::OP0_SYS
      && acc_code_in.crn == label_pkg::CRN_LABEL
      && acc_code_in.crm == label_pkg::CRM_CTRL
      && acc_code_in.op1 == label_pkg::OP1_EL1
      && acc_code_in.op2 == label_pkg::OP2_ID;
  assign lower_trap_on = HAVE_EL3 && lower_trap_r;
  assign el2_on = el2_enabled_in;
  assign nested_all = nested_virt_memory_in && nested_virt_secondary_in
      && nested_virt_control_in;

  // Outcome per access; the order of tests is the priority of checks.
  always_comb begin
    outcome = label_pkg::ACC_DONE;
    wr_el2 = 1'b0;
    wr_el3 = 1'b0;
    wr_ctrl = 1'b0;
    el1_write_out = 1'b0;
    rdata = 64'h0;
    if (hit_label && acc_code_in.op1 == label_pkg::OP1_EL3) begin
      if (acc_level_in != label_pkg::EL3 || !HAVE_EL3) begin
        outcome = label_pkg::ACC_UNDEF;
      end else begin
        wr_el3 = acc_write_in;
        rdata = {enable_r, lower_trap_r, 14'h0, el3_fields_r};
      end
    end else if (hit_label && acc_code_in.op1 == label_pkg::OP1_EL2) begin
      if (acc_level_in == label_pkg::EL0) begin
        outcome = label_pkg::ACC_UNDEF;
      end else if (acc_level_in == label_pkg::EL1) begin
        if (acc_write_in && el2_on && nested_virt_control_in) begin
          outcome = lower_trap_on ? label_pkg::ACC_TRAP_EL3
                                  : label_pkg::ACC_TRAP_EL2;
        end else begin
          outcome = label_pkg::ACC_UNDEF;
        end
      end else if (acc_level_in == label_pkg::EL2 && lower_trap_on) begin
        outcome = label_pkg::ACC_TRAP_EL3;
      end else begin
        wr_el2 = acc_write_in;
        rdata = {enable_r, 13'h0, el0_trap_r, el1_trap_r, el2_fields_r};
      end
    end else if (hit_label && acc_code_in.op1 == label_pkg::OP1_EL1) begin
      if (acc_level_in == label_pkg::EL0) begin
        outcome = label_pkg::ACC_UNDEF;
      end else if (acc_level_in != label_pkg::EL3 && lower_trap_on) begin
        outcome = label_pkg::ACC_TRAP_EL3;
      end else if (acc_level_in == label_pkg::EL1 && el2_on
                   && el1_trap_r) begin
        outcome = label_pkg::ACC_TRAP_EL2;
      end else if (acc_level_in == label_pkg::EL1 && el2_on
                   && nested_all) begin
        outcome = label_pkg::ACC_MEM;
      end else if (acc_level_in == label_pkg::EL2
                   && host_mode_control_in) begin
        wr_el2 = acc_write_in;
        rdata = {enable_r, 13'h0, el0_trap_r, el1_trap_r, el2_fields_r};
      end else begin
        el1_write_out = acc_write_in;
        rdata = {enable_r, el1_label_register_in};
      end
    end else if (el0_reg_access_in) begin
      if (acc_level_in == label_pkg::EL0) begin
        outcome = label_pkg::ACC_UNDEF;
      end else if (acc_level_in != label_pkg::EL3 && lower_trap_on) begin
        outcome = label_pkg::ACC_TRAP_EL3;
      end else if (acc_level_in == label_pkg::EL1 && el2_on
                   && el0_trap_r) begin
        outcome = label_pkg::ACC_TRAP_EL2;
      end
    end else if (hit_ctrl) begin
      if (!HAVE_VIRT || acc_level_in == label_pkg::EL0
          || acc_level_in == label_pkg::EL1) begin
        outcome = label_pkg::ACC_UNDEF;
      end else if (acc_level_in == label_pkg::EL2 && lower_trap_on) begin
        outcome = label_pkg::ACC_TRAP_EL3;
      end else begin
        wr_ctrl = acc_write_in;
        rdata = {32'h0, id_trap_r, 29'h0, vmap_r};
      end
    end else if (hit_id) begin
      if (acc_level_in == label_pkg::EL0) begin
        outcome = label_pkg::ACC_UNDEF;
      end else if (acc_level_in != label_pkg::EL3 && lower_trap_on) begin
        outcome = label_pkg::ACC_TRAP_EL3;
      end else if (acc_level_in == label_pkg::EL1 && el2_on && HAVE_VIRT
                   && id_trap_r) begin
        outcome = label_pkg::ACC_TRAP_EL2;
      end
    end else begin
      outcome = label_pkg::ACC_UNDEF;
    end
    if (!acc_valid_in) begin
      wr_el2 = 1'b0;
      wr_el3 = 1'b0;
      wr_ctrl = 1'b0;
      el1_write_out = 1'b0;
    end
  end

  // Answers are registered so the pipeline sees them one cycle later.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      acc_rdata_out <= 64'h0;
      acc_outcome_out <= label_pkg::ACC_DONE;
      trap_class_out <= 6'h0;
      mem_offset_out <= 12'h0;
    end else begin
      acc_rdata_out <= (acc_valid_in && !acc_write_in) ? rdata : 64'h0;
      acc_outcome_out <= acc_valid_in ? outcome : label_pkg::ACC_DONE;
      trap_class_out <= label_pkg::TRAP_CLASS;
      mem_offset_out <= label_pkg::MEM_EL1_OFS;
    end
  end

  // ------------------------------------------------------------------
  // Register updates
  // ------------------------------------------------------------------
  // Shared enable; only the owning register may write it.
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      enable_r <= label_pkg::RST_ENABLE;
    end else if (wr_el3) begin
      enable_r <= acc_wdata_in[label_pkg::ENABLE_BIT];
    end else if (wr_el2 && !HAVE_EL3) begin
      enable_r <= acc_wdata_in[label_pkg::ENABLE_BIT];
    end
  end

  // Lower trap resets to one only on a cold reset; a warm reset keeps it.
  always_ff @(posedge clk_in) begin
    if (reset_in && cold_reset_in) begin
      lower_trap_r <= label_pkg::RST_LOWER_TRAP;
    end else if (wr_el3) begin
      lower_trap_r <= acc_wdata_in[label_pkg::LOWER_TRAP_BIT];
    end
  end

  // EL2 trap bits: defined reset only without EL3 and into 64-bit.
  always_ff @(posedge clk_in) begin
    if (reset_in && !HAVE_EL3 && reset_64bit_in) begin
      el0_trap_r <= label_pkg::RST_EL2_TRAPS;
      el1_trap_r <= label_pkg::RST_EL2_TRAPS;
      id_trap_r  <= label_pkg::RST_EL2_TRAPS;
    end else if (!reset_in) begin
      if (wr_el2) begin
        el0_trap_r <= acc_wdata_in[label_pkg::EL0_TRAP_BIT];
        el1_trap_r <= acc_wdata_in[label_pkg::EL1_TRAP_BIT];
      end
      if (wr_ctrl) begin
        id_trap_r <= acc_wdata_in[label_pkg::ID_TRAP_BIT];
      end
    end
  end

  // Label fields reset to unknown, so no reset term is given.
  always_ff @(posedge clk_in) begin
    if (wr_el2) begin
      el2_fields_r <= acc_wdata_in[47:0];
    end
    if (wr_el3) begin
      el3_fields_r <= acc_wdata_in[47:0];
    end
    if (wr_ctrl) begin
      vmap_r <= acc_wdata_in[label_pkg::EL1_VMAP_BIT:
                             label_pkg::EL0_VMAP_BIT];
    end
  end

  // ------------------------------------------------------------------
  // Label generation
  // ------------------------------------------------------------------
  // Fields come straight from the live registers; nothing is cached.
  logic [47:0] sel_fields;
  logic        el1_virtual;
  logic [15:0] raw_part;
  logic [7:0]  raw_group;

  always_comb begin
    case (cur_level_in)
      label_pkg::EL3: sel_fields = el3_fields_r;
      label_pkg::EL2: sel_fields = el2_fields_r;
      default:        sel_fields = el1_label_register_in[47:0];
    endcase
  end

  assign raw_part  = req_is_data_in ? sel_fields[31:16]
                                    : sel_fields[15:0];
  assign raw_group = req_is_data_in ? sel_fields[47:40]
                                    : sel_fields[39:32];
  assign el1_virtual = HAVE_VIRT && el2_on && ((cur_level_in ==
      label_pkg::EL1 && vmap_r[1]) || (cur_level_in == label_pkg::EL0
      && vmap_r[0]));
  assign virtual_partition_out = raw_part;
  assign virtual_map_out = el1_virtual;
  assign label_enable_out = enable_r;

  // Output label register: default values while labelling is off.
  always_ff @(posedge clk_in) begin
    if (reset_in || !enable_r) begin
      label_out <= '{label_pkg::DEFAULT_PARTITION,
                     label_pkg::DEFAULT_GROUP};
    end else begin
      label_out <= '{el1_virtual ? mapped_partition_in : raw_part,
                     raw_group};
    end
  end

endmodule

`default_nettype wire

// *** partition_label_regs_bench.sv ***
/*
  Self-checking bench for the request label register bank.
  Assumes the default build with the top level present.
*/
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Bench
// ------------------------------------------------------------------
module partition_label_regs_bench;
  logic clk_in, reset_in, cold, valid, wr, el2_en, host, nv, nv1, nv2;
  logic el0_acc, is_data, el1_wr, en_out, vmap;
  logic [15:0] mapped, vpart;
  label_pkg::sysreg_code_type code;
  label_pkg::level_type       lvl, cur;
  label_pkg::outcome_type     outc;
  label_pkg::label_type       lab;
  logic [63:0] wdata, rd, rdata;
  logic [62:0] el1_val;
  logic [5:0]  tclass;
  logic [11:0] mofs;
  int n_mismatch = 0;
  int total_checks = 0;
  localparam logic [2:0] OP1S [6] = '{3'h0, 3'h4, 3'h6, 3'h4, 3'h0, 3'h0};
  localparam logic [63:0] W3 = 64'h8000_5a3c_1234_5678;

  partition_label_regs u_dut (.clk_in(clk_in), .reset_in(reset_in),
    .cold_reset_in(cold), .reset_64bit_in(1'b1), .acc_valid_in(valid),
    .acc_write_in(wr), .acc_code_in(code), .acc_level_in(lvl),
    .acc_wdata_in(wdata), .el2_enabled_in(el2_en),
    .host_mode_control_in(host), .nested_virt_control_in(nv),
    .nested_virt_secondary_in(nv1), .nested_virt_memory_in(nv2),
    .el0_reg_access_in(el0_acc), .el1_label_register_in(el1_val),
    .cur_level_in(cur), .req_is_data_in(is_data),
    .mapped_partition_in(mapped), .el1_write_out(el1_wr),
    .acc_rdata_out(rdata), .acc_outcome_out(outc),
    .trap_class_out(tclass), .mem_offset_out(mofs),
    .label_enable_out(en_out), .virtual_partition_out(vpart),
    .virtual_map_out(vmap), .label_out(lab));
  el1_store_model u_store (.clk_in(clk_in), .write_in(el1_wr),
    .wdata_in(wdata), .value_out(el1_val));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input logic [63:0] got, exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got,
               exp);
    end
  endtask

  // One access: sel 0..5 is lower, middle, top, control, id, EL0 register.
  // The EL0 code hits no register of the bank, so only its trap applies.
  task automatic acc(input label_pkg::level_type lv, input logic w,
      input int sel, input logic [63:0] d,
      input label_pkg::outcome_type exp);
    @(negedge clk_in);
    lvl = lv;
    wr = w;
    wdata = d;
    code = {2'h3, OP1S[sel], 4'ha, (sel inside {3, 4}) ? 4'h4 : 4'h5,
            (sel == 4) ? 3'h4 : ((sel == 5) ? 3'h1 : 3'h0)};
    valid = 1'b1;
    @(negedge clk_in);
    chk(64'(outc), 64'(exp), "outcome");
    rd = rdata;
    valid = 1'b0;
  endtask

  task automatic t_reset();
    acc(label_pkg::EL3, 0, 2, 0, label_pkg::ACC_DONE);
    chk(rd[63:62], 2'b01, "reset enable and trap");
    acc(label_pkg::EL2, 0, 1, 0, label_pkg::ACC_TRAP_EL3);
    chk(tclass, 6'h18, "class");
    acc(label_pkg::EL2, 1, 2, 0, label_pkg::ACC_UNDEF);
    acc(label_pkg::EL0, 1, 1, 0, label_pkg::ACC_UNDEF);
    $display("test reset done");
  endtask

  task automatic t_regs();
    acc(label_pkg::EL3, 1, 2, W3, label_pkg::ACC_DONE);
    acc(label_pkg::EL3, 0, 2, 0, label_pkg::ACC_DONE);
    chk(rd, W3, "top register");
    chk(en_out, 1'b1, "enable");
    acc(label_pkg::EL3, 1, 1, 64'h0003_a1b2_c3c3_d4d4,
        label_pkg::ACC_DONE);
    acc(label_pkg::EL3, 0, 1, 0, label_pkg::ACC_DONE);
    chk(rd[63], 1'b1, "middle enable");
    chk(rd[49:0], 50'h3_a1b2_c3c3_d4d4, "middle fields");
    $display("test regs done");
  endtask

  task automatic t_label();
    el2_en = 1'b1;
    cur = label_pkg::EL2;
    is_data = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(lab, {16'hc3c3, 8'ha1}, "data label");
    is_data = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(lab, {16'hd4d4, 8'hb2}, "instr label");
    acc(label_pkg::EL3, 1, 2, {1'b0, W3[62:0]}, label_pkg::ACC_DONE);
    repeat (2) @(negedge clk_in);
    chk(lab, {label_pkg::DEFAULT_PARTITION, label_pkg::DEFAULT_GROUP},
        "default label");
    acc(label_pkg::EL3, 1, 2, W3, label_pkg::ACC_DONE);
    $display("test label done");
  endtask

  task automatic t_lower();
    acc(label_pkg::EL1, 0, 0, 0, label_pkg::ACC_TRAP_EL2);
    el0_acc = 1'b1;
    acc(label_pkg::EL1, 0, 5, 0, label_pkg::ACC_TRAP_EL2);
    el0_acc = 1'b0;
    acc(label_pkg::EL3, 1, 1, 64'h0000_a1b2_c3c3_d4d4,
        label_pkg::ACC_DONE);
    el0_acc = 1'b1;
    acc(label_pkg::EL1, 0, 5, 0, label_pkg::ACC_DONE);
    el0_acc = 1'b0;
    {nv, nv1, nv2} = 3'b111;
    acc(label_pkg::EL1, 1, 0, 0, label_pkg::ACC_MEM);
    chk(mofs, 12'h900, "offset");
    {nv1, nv2} = 2'b00;
    acc(label_pkg::EL1, 1, 1, 0, label_pkg::ACC_TRAP_EL2);
    nv = 1'b0;
    acc(label_pkg::EL1, 1, 0, 64'h0000_1111_2222_3333,
        label_pkg::ACC_DONE);
    acc(label_pkg::EL1, 0, 0, 0, label_pkg::ACC_DONE);
    chk(rd[62:0], 63'h1111_2222_3333, "lower register");
    host = 1'b1;
    acc(label_pkg::EL2, 0, 0, 0, label_pkg::ACC_DONE);
    chk(rd[47:0], 48'ha1b2_c3c3_d4d4, "host redirect");
    host = 1'b0;
    acc(label_pkg::EL3, 1, 3, 64'h8000_0002, label_pkg::ACC_DONE);
    acc(label_pkg::EL1, 0, 4, 0, label_pkg::ACC_TRAP_EL2);
    cur = label_pkg::EL1;
    is_data = 1'b1;
    mapped = 16'h0042;
    repeat (2) @(negedge clk_in);
    chk(lab, {16'h0042, 8'h11}, "mapped label");
    chk(vpart, 16'h2222, "virtual id");
    chk(vmap, 1'b1, "map enable");
    acc(label_pkg::EL3, 1, 2, 64'hc000_0000_0000_0000,
        label_pkg::ACC_DONE);
    acc(label_pkg::EL1, 0, 0, 0, label_pkg::ACC_TRAP_EL3);
    $display("test lower done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A hang well past the roughly sixty cycles of the tests ends the run.
  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end

  initial begin
    {reset_in, cold} = 2'b11;
    {valid, wr, el2_en, host, nv, nv1, nv2, el0_acc, is_data} = '0;
    code = '0;
    lvl = label_pkg::EL3;
    cur = label_pkg::EL3;
    wdata = '0;
    mapped = '0;
    repeat (4) @(negedge clk_in);
    {reset_in, cold} = 2'b00;
    t_reset();
    t_regs();
    t_label();
    t_lower();
    summarize();
  end
endmodule
`default_nettype wire

// *** partition_label_regs_checker.sv ***
/*
  Concurrent checks on the ports of the request label register bank.
  Assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------------
// Port checker
// ------------------------------------------------------------------
module partition_label_regs_checker (
  input wire logic                       clk_in,
  input wire logic                       reset_in,
  input wire logic                       acc_valid_in,
  input wire logic                       acc_write_in,
  input wire label_pkg::sysreg_code_type acc_code_in,
  input wire label_pkg::level_type       acc_level_in,
  input wire logic [63:0]                acc_wdata_in,
  input wire logic                       el1_write_out,
  input wire logic [63:0]                acc_rdata_out,
  input wire label_pkg::outcome_type     acc_outcome_out,
  input wire logic [5:0]                 trap_class_out,
  input wire logic [11:0]                mem_offset_out,
  input wire logic                       label_enable_out,
  input wire label_pkg::label_type       label_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // Decoded selections of the two label registers.
  logic sel_el3;
  logic sel_el2;
  assign sel_el3 = acc_valid_in && acc_code_in.op1 == 3'h6
                   && acc_code_in.crm == 4'h5;
  assign sel_el2 = acc_valid_in && acc_code_in.op1 == 3'h4
                   && acc_code_in.crm == 4'h5;

  AST_DEFAULT_LABEL: assert property (!label_enable_out |=>
    label_out == {16'h0000, 8'h00}) else $error("label not default");
  AST_ENABLE_RESET: assert property ($past(reset_in) |->
    !label_enable_out) else $error("enable set after reset");
  AST_EL3_UNDEF: assert property (sel_el3 && acc_level_in !=
    label_pkg::EL3 |=> acc_outcome_out == label_pkg::ACC_UNDEF)
    else $error("low level reached top register");
  AST_EL3_DONE: assert property (sel_el3 && acc_level_in ==
    label_pkg::EL3 |=> acc_outcome_out == label_pkg::ACC_DONE)
    else $error("top level access refused");
  AST_EL0_WRITE: assert property (sel_el2 && acc_write_in
    && acc_level_in == label_pkg::EL0 |=>
    acc_outcome_out == label_pkg::ACC_UNDEF) else $error("el0 write");
  AST_TRAP_CLASS: assert property (acc_outcome_out inside
    {label_pkg::ACC_TRAP_EL2, label_pkg::ACC_TRAP_EL3} |->
    trap_class_out == 6'h18) else $error("bad trap class");
  AST_MEM_OFFSET: assert property (acc_outcome_out ==
    label_pkg::ACC_MEM |-> mem_offset_out == 12'h900)
    else $error("bad memory offset");
  AST_ENABLE_WRITE: assert property (sel_el3 && acc_write_in
    && acc_level_in == label_pkg::EL3 |=>
    label_enable_out == $past(acc_wdata_in[63])) else $error("enable");
  AST_SHARED_READ: assert property (sel_el2 && !acc_write_in
    && acc_level_in == label_pkg::EL3 |=>
    acc_rdata_out[63] == label_enable_out) else $error("shared bit");
  AST_EL1_WRITE: assert property (el1_write_out |-> acc_valid_in
    && acc_write_in && acc_level_in != label_pkg::EL0)
    else $error("stray lower register write");

  COV_TRAP3: cover property (acc_outcome_out == label_pkg::ACC_TRAP_EL3);
  COV_MEM: cover property (acc_outcome_out == label_pkg::ACC_MEM);
  COV_EN: cover property ($rose(label_enable_out));
endmodule

bind partition_label_regs partition_label_regs_checker u_chk (
  .clk_in(clk_in), .reset_in(reset_in), .acc_valid_in(acc_valid_in),
  .acc_write_in(acc_write_in), .acc_code_in(acc_code_in),
  .acc_level_in(acc_level_in), .acc_wdata_in(acc_wdata_in),
  .el1_write_out(el1_write_out), .acc_rdata_out(acc_rdata_out),
  .acc_outcome_out(acc_outcome_out), .trap_class_out(trap_class_out),
  .mem_offset_out(mem_offset_out), .label_enable_out(label_enable_out),
  .label_out(label_out));
`default_nettype wire
